// ---- hsp_pkg.sv ----
// Purpose: Shared types and constants of the host serial port
// Assumes: 100 MHz clk, AXI4-Lite with byte addresses
// Notes: All register words are 32 bits, reserved bits read zero
`default_nettype none
package hsp_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RATE = 8'h04;
  localparam logic [7:0] OFF_TMR = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_MAXPL = 8'h10;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ==========================================
  // Buffers and thresholds
  localparam logic [6:0] BUF_DEPTH = 7'h40;
  localparam logic [6:0] CTS_STOP_FREE = 7'h11;
  localparam logic [6:0] CTS_GO_FREE = 7'h22;
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [1:0] CC_COUNT = 2'h3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_FAIL = 8'h01;
  // ==========================================
  // Register layouts
  typedef struct packed {
    logic [24:0] rsvd;
    logic stop2;
    logic [1:0] parity_setting;
    logic cmdmode;
    logic framed;
    logic receive_throttle_enable;
    logic output_holdoff_enable;
  } hsp_ctrl_t;
  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] command_entry_character;
    logic [7:0] guard_silence_interval;
    logic [7:0] packetize_silence_timeout;
  } hsp_tmr_t;
  typedef struct packed {
    hsp_ctrl_t ctrl;
    logic [31:0] rate;
    hsp_tmr_t tmr;
    logic [31:0] maxpl;
  } hsp_cfg_t;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_RATE = 32'h0000_0364;
  localparam logic [31:0] RST_TMR = 32'h002b_1e1e;
  localparam logic [31:0] RST_MAXPL = 32'h0000_0030;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } hsp_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hsp_axi_rsp_t;
  typedef struct packed {
    logic start;
    logic [6:0] len;
    logic [7:0] src;
    logic valid;
    logic [7:0] data;
  } hsp_prx_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } hsp_ptx_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_START = 5'b00010,
    S_DATA = 5'b00100,
    S_PAR = 5'b01000,
    S_STOP = 5'b10000
  } hsp_ser_t;
endpackage
`default_nettype wire

// ---- hsp_top.sv ----
// Purpose: Host serial port with buffers, flow control, packetizing
// Assumes: rxd and rts_n synchronous to clk
// Notes: Register bus, serial pins and radio side share one state struct
// Functional notes
// R1 - Host idles its data line high
// R2 - Start low, eight data LSB first, stop high
// R3 - Rate, parity, stop bits set separately
// R4 - Every received character stored in receive buffer
// R5 - Defer draining while radio keeps receiving
// R6 - Radio packet not fitting dropped whole
// R7 - Throttle when 17 bytes free remain
// R8 - Release throttle at 34 bytes free
// R9 - Host stops sending while throttled
// R10 - No new output while host holds off
// R11 - At most five characters after hold-off
// R12 - Host keeps hold-off short
// R13 - Separate enables for both handshake directions
// R14 - Transparent: queue serial, output radio payloads
// R15 - Packetize after silence; zero means immediately
// R16 - Command sequence flushes earlier characters first
// R17 - Packetize at full radio payload
// R18 - Framed mode carries everything in frames; host data to the radio stays unframed
// R19 - Framed: deliver data, responses and events
// R20 - Framed: report status per transmit
// R21 - Framed: received data carries source address
// R22 - No forwarding while in command mode
// R23 - Centre sampling, bad stop discards character
`default_nettype none
module hsp_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input wire hsp_pkg::hsp_axi_req_t axi_req,
  output var hsp_pkg::hsp_axi_rsp_t axi_rsp,
  // Host serial pins
  input wire logic rxd,
  input wire logic rts_n,
  output var logic txd,
  output var logic cts_n,
  // Radio packet engine
  input wire logic radio_rx_busy,
  output var hsp_pkg::hsp_ptx_t ptx,
  input wire logic ptx_ready,
  input wire hsp_pkg::hsp_prx_t prx,
  input wire logic tx_status_valid,
  input wire logic tx_status_ok,
  input wire logic event_valid,
  input wire logic [7:0] event_code
);
  import hsp_pkg::*;

  typedef struct packed {
    hsp_cfg_t cfg;
    hsp_axi_rsp_t rsp;
    logic aw_full;
    logic [7:0] awa;
    logic w_full;
    logic [31:0] wd;
    logic [3:0] ws;
    hsp_ser_t rs;
    logic [15:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rpar;
    logic perr;
    logic [7:0] ferr;
    logic [63:0][7:0] rmem;
    logic [5:0] rwp;
    logic [5:0] rrp;
    logic [6:0] rnum;
    logic cts_n;
    logic [15:0] bdiv;
    logic [7:0] sil;
    logic [1:0] ccnt;
    logic [1:0] rep;
    logic [7:0] hold;
    logic hold_v;
    logic fpend;
    logic [6:0] burst;
    hsp_ptx_t ptx;
    logic [63:0][7:0] tmem;
    logic [5:0] twp;
    logic [5:0] trp;
    logic [6:0] tnum;
    logic [6:0] rem;
    logic drop;
    logic st_pend;
    logic [7:0] st_byte;
    logic ev_pend;
    logic [7:0] ev_byte;
    hsp_ser_t ts;
    logic [15:0] tcnt;
    logic [3:0] tbit;
    logic [7:0] tsh;
    logic tpar;
    logic txd;
  } hsp_st_t;

  hsp_st_t s_reg;
  hsp_st_t s_next;
  logic ch_ev;
  logic push_v;
  logic [7:0] push_d;
  logic push_ok;
  logic pop;
  logic tpush;
  logic [7:0] tpush_d;
  logic tpop;
  logic [31:0] rd;
  logic rd_ok;
  logic [6:0] rfree;
  logic [6:0] tfree;
  logic [15:0] rate;
  logic [6:0] maxpl;
  logic [31:0] wm;

  // Byte-lane merge for register writes
  function automatic logic [31:0] hsp_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    ch_ev = 1'b0;
    push_v = 1'b0;
    push_d = s_reg.rsh;
    pop = 1'b0;
    tpush = 1'b0;
    tpush_d = prx.data;
    tpop = 1'b0;
    rd = 32'h0;
    rd_ok = 1'b1;
    wm = 32'h0;
    rate = s_reg.cfg.rate[15:0]; // [R3]
    maxpl = s_reg.cfg.maxpl[6:0];
    rfree = BUF_DEPTH - s_reg.rnum;
    tfree = BUF_DEPTH - s_reg.tnum;
    // Register read decode
    if (s_reg.rsp.arready && axi_req.arvalid) begin
      if (axi_req.araddr == OFF_CTRL) begin
        rd = s_reg.cfg.ctrl;
      end else if (axi_req.araddr == OFF_RATE) begin
        rd = s_reg.cfg.rate;
      end else if (axi_req.araddr == OFF_TMR) begin
        rd = s_reg.cfg.tmr;
      end else if (axi_req.araddr == OFF_STAT) begin
        rd = {s_reg.ferr, 7'h0, s_reg.cts_n, 1'b0, s_reg.tnum, 1'b0, s_reg.rnum};
      end else if (axi_req.araddr == OFF_MAXPL) begin
        rd = s_reg.cfg.maxpl;
      end else begin
        rd_ok = 1'b0;
      end
      s_next.rsp.rvalid = 1'b1;
      s_next.rsp.rdata = rd;
      s_next.rsp.rresp = rd_ok ? RESP_OK : RESP_ERR;
    end else if (s_reg.rsp.rvalid && axi_req.rready) begin
      s_next.rsp.rvalid = 1'b0;
    end
    s_next.rsp.arready = !s_next.rsp.rvalid;
    // Write channel capture, either order
    if (axi_req.awvalid && s_reg.rsp.awready) begin
      s_next.aw_full = 1'b1;
      s_next.awa = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_reg.rsp.wready) begin
      s_next.w_full = 1'b1;
      s_next.wd = axi_req.wdata;
      s_next.ws = axi_req.wstrb;
    end
    if (s_reg.rsp.bvalid && axi_req.bready) begin
      s_next.rsp.bvalid = 1'b0;
    end
    // Register write, response after both halves
    if (s_reg.aw_full && s_reg.w_full && !s_reg.rsp.bvalid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.rsp.bvalid = 1'b1;
      s_next.rsp.bresp = RESP_OK;
      if (s_reg.awa == OFF_CTRL) begin
        s_next.cfg.ctrl = hsp_merge(s_reg.cfg.ctrl, s_reg.wd, s_reg.ws); // [R13]
        s_next.cfg.ctrl.rsvd = '0;
      end else if (s_reg.awa == OFF_RATE) begin
        wm = hsp_merge(s_reg.cfg.rate, s_reg.wd, s_reg.ws);
        s_next.cfg.rate[15:0] = wm[15:0];
      end else if (s_reg.awa == OFF_TMR) begin
        s_next.cfg.tmr = hsp_merge(s_reg.cfg.tmr, s_reg.wd, s_reg.ws);
        s_next.cfg.tmr.rsvd = '0;
      end else if (s_reg.awa == OFF_MAXPL) begin
        wm = hsp_merge(s_reg.cfg.maxpl, s_reg.wd, s_reg.ws);
        s_next.cfg.maxpl[6:0] = wm[6:0];
      end else if (s_reg.awa != OFF_STAT) begin
        s_next.rsp.bresp = RESP_ERR;
      end
    end

    // Serial receiver, centre sampled
    if (s_reg.rcnt != 16'h0) begin
      s_next.rcnt = s_reg.rcnt - 16'h1;
    end
    case (s_reg.rs)
      S_IDLE: begin
        if (!rxd) begin
          s_next.rs = S_START;
          s_next.rcnt = rate >> 1; // [R23]
        end
      end
      S_START: begin
        if (s_reg.rcnt == 16'h0) begin
          s_next.rs = rxd ? S_IDLE : S_DATA; // [R2]
          s_next.rcnt = rate - 16'h1;
          s_next.rbit = 4'h0;
          s_next.rpar = 1'b0;
          s_next.perr = 1'b0;
        end
      end
      S_DATA: begin
        if (s_reg.rcnt == 16'h0) begin
          s_next.rsh = {rxd, s_reg.rsh[7:1]}; // [R2]
          s_next.rpar = s_reg.rpar ^ rxd;
          s_next.rbit = s_reg.rbit + 4'h1;
          s_next.rcnt = rate - 16'h1;
          if (s_reg.rbit == BITS_LAST) begin
            s_next.rs = (s_reg.cfg.ctrl.parity_setting != PAR_NONE) ? S_PAR : S_STOP;
          end
        end
      end
      S_PAR: begin
        if (s_reg.rcnt == 16'h0) begin
          s_next.perr = (s_reg.rpar ^ rxd) != (s_reg.cfg.ctrl.parity_setting == PAR_ODD);
          s_next.rcnt = rate - 16'h1;
          s_next.rs = S_STOP;
        end
      end
      S_STOP: begin
        if (s_reg.rcnt == 16'h0) begin
          s_next.rs = S_IDLE;
          if (rxd && !s_reg.perr) begin
            ch_ev = 1'b1;
          end else if (s_reg.ferr != 8'hff) begin
            s_next.ferr = s_reg.ferr + 8'h1; // [R23]
          end
        end
      end
      default: s_next.rs = S_IDLE;
    endcase

    // Silence timer in bit periods
    if (s_reg.bdiv == 16'h0) begin
      s_next.bdiv = rate - 16'h1;
      if (s_reg.sil != 8'hff) begin
        s_next.sil = s_reg.sil + 8'h1;
      end
    end else begin
      s_next.bdiv = s_reg.bdiv - 16'h1;
    end
    // Command sequence watch and receive queueing
    if (ch_ev) begin
      s_next.sil = 8'h0;
      if (s_reg.cfg.ctrl.cmdmode) begin
        push_v = 1'b0; // [R22]
      end else if (s_reg.rsh == s_reg.cfg.tmr.command_entry_character &&
                   ((s_reg.ccnt == 2'h0 &&
                     s_reg.sil >= s_reg.cfg.tmr.guard_silence_interval) ||
                    (s_reg.ccnt != 2'h0 && s_reg.ccnt != CC_COUNT))) begin
        s_next.ccnt = s_reg.ccnt + 2'h1;
      end else if (s_reg.ccnt != 2'h0) begin
        s_next.rep = s_reg.ccnt;
        s_next.hold = s_reg.rsh;
        s_next.hold_v = 1'b1;
        s_next.ccnt = 2'h0;
      end else begin
        push_v = 1'b1; // [R4] [R14]
      end
    end else if (s_reg.rep != 2'h0) begin
      push_v = 1'b1;
      push_d = s_reg.cfg.tmr.command_entry_character;
      s_next.rep = s_reg.rep - 2'h1;
    end else if (s_reg.hold_v) begin
      push_v = 1'b1;
      push_d = s_reg.hold;
      s_next.hold_v = 1'b0;
    end else if (s_reg.ccnt == CC_COUNT &&
                 s_reg.sil >= s_reg.cfg.tmr.guard_silence_interval) begin
      s_next.ccnt = 2'h0;
      s_next.fpend = 1'b1; // [R16]
    end
    push_ok = push_v && s_reg.rnum != BUF_DEPTH;

    // Packetizer trigger
    if (s_reg.fpend && s_reg.rnum == 7'h0 && s_reg.burst == 7'h0) begin
      s_next.fpend = 1'b0;
      s_next.cfg.ctrl.cmdmode = 1'b1;
    end
    if (s_reg.burst == 7'h0 && s_reg.rnum != 7'h0 && !radio_rx_busy && // [R5]
        (s_reg.cfg.tmr.packetize_silence_timeout == 8'h0 || // [R15]
         s_reg.sil >= s_reg.cfg.tmr.packetize_silence_timeout ||
         s_reg.rnum >= maxpl || s_reg.fpend)) begin // [R17]
      s_next.burst = (s_reg.rnum >= maxpl) ? maxpl : s_reg.rnum;
    end
    // Packet output to the radio engine
    if (!s_reg.ptx.valid || ptx_ready) begin
      s_next.ptx.valid = 1'b0;
      if (s_reg.burst != 7'h0) begin
        pop = 1'b1;
        s_next.ptx.valid = 1'b1;
        s_next.ptx.data = s_reg.rmem[s_reg.rrp];
        s_next.ptx.last = s_reg.burst == 7'h1;
        s_next.burst = s_reg.burst - 7'h1;
      end
    end
    // Receive buffer bookkeeping
    if (push_ok) begin
      s_next.rmem[s_reg.rwp] = push_d;
      s_next.rwp = s_reg.rwp + 6'h1;
    end
    if (pop) begin
      s_next.rrp = s_reg.rrp + 6'h1;
    end
    s_next.rnum = s_reg.rnum + {6'h0, push_ok} - {6'h0, pop};
    // Throttle with hysteresis
    if (!s_reg.cfg.ctrl.receive_throttle_enable) begin
      s_next.cts_n = 1'b0;
    end else if (rfree <= CTS_STOP_FREE) begin
      s_next.cts_n = 1'b1; // [R7]
    end else if (rfree >= CTS_GO_FREE) begin
      s_next.cts_n = 1'b0; // [R8]
    end

    // Transmit buffer filling
    if (prx.start) begin
      s_next.rem = prx.len;
      s_next.drop = {1'b0, tfree} < ({1'b0, prx.len} + {7'h0, s_reg.cfg.ctrl.framed}); // [R6]
      if (!s_next.drop && s_reg.cfg.ctrl.framed) begin
        tpush = 1'b1; // [R21]
        tpush_d = prx.src;
      end
    end else if (prx.valid && s_reg.rem != 7'h0) begin
      s_next.rem = s_reg.rem - 7'h1;
      tpush = !s_reg.drop; // [R14] [R6]
    end else if (s_reg.rem == 7'h0 && s_reg.st_pend) begin
      tpush = 1'b1; // [R20]
      tpush_d = s_reg.st_byte;
      s_next.st_pend = 1'b0;
    end else if (s_reg.rem == 7'h0 && s_reg.ev_pend) begin
      tpush = 1'b1; // [R19]
      tpush_d = s_reg.ev_byte;
      s_next.ev_pend = 1'b0;
    end
    // New status and events win over their clear
    if (tx_status_valid && s_reg.cfg.ctrl.framed) begin
      s_next.st_pend = 1'b1; // [R18] [R20]
      s_next.st_byte = tx_status_ok ? ST_OK : ST_FAIL;
    end
    if (event_valid && s_reg.cfg.ctrl.framed) begin
      s_next.ev_pend = 1'b1; // [R19]
      s_next.ev_byte = event_code;
    end
    tpush = tpush && s_reg.tnum != BUF_DEPTH;

    // Serial transmitter
    if (s_reg.tcnt != 16'h0) begin
      s_next.tcnt = s_reg.tcnt - 16'h1;
    end
    case (s_reg.ts)
      S_IDLE: begin
        s_next.txd = 1'b1;
        if (s_reg.tnum != 7'h0 && // [R10] [R11]
            !(s_reg.cfg.ctrl.output_holdoff_enable && rts_n)) begin
          tpop = 1'b1;
          s_next.tsh = s_reg.tmem[s_reg.trp];
          s_next.ts = S_START;
          s_next.txd = 1'b0; // [R2]
          s_next.tcnt = rate - 16'h1;
          s_next.tbit = 4'h0;
        end
      end
      S_START: begin
        if (s_reg.tcnt == 16'h0) begin
          s_next.ts = S_DATA;
          s_next.txd = s_reg.tsh[0]; // [R2]
          s_next.tpar = s_reg.tsh[0];
          s_next.tsh = s_reg.tsh >> 1;
          s_next.tcnt = rate - 16'h1;
        end
      end
      S_DATA: begin
        if (s_reg.tcnt == 16'h0) begin
          s_next.tcnt = rate - 16'h1;
          if (s_reg.tbit == BITS_LAST) begin
            s_next.tbit = 4'h0;
            if (s_reg.cfg.ctrl.parity_setting != PAR_NONE) begin
              s_next.ts = S_PAR; // [R3]
              s_next.txd = s_reg.tpar ^ (s_reg.cfg.ctrl.parity_setting == PAR_ODD);
            end else begin
              s_next.ts = S_STOP;
              s_next.txd = 1'b1;
            end
          end else begin
            s_next.txd = s_reg.tsh[0];
            s_next.tpar = s_reg.tpar ^ s_reg.tsh[0];
            s_next.tsh = s_reg.tsh >> 1;
            s_next.tbit = s_reg.tbit + 4'h1;
          end
        end
      end
      S_PAR: begin
        if (s_reg.tcnt == 16'h0) begin
          s_next.ts = S_STOP;
          s_next.txd = 1'b1; // [R2]
          s_next.tcnt = rate - 16'h1;
        end
      end
      S_STOP: begin
        if (s_reg.tcnt == 16'h0) begin
          if (s_reg.cfg.ctrl.stop2 && s_reg.tbit == 4'h0) begin
            s_next.tbit = 4'h1; // [R3]
            s_next.tcnt = rate - 16'h1;
          end else begin
            s_next.ts = S_IDLE;
          end
        end
      end
      default: s_next.ts = S_IDLE;
    endcase
    // Transmit buffer bookkeeping
    if (tpush) begin
      s_next.tmem[s_reg.twp] = tpush_d;
      s_next.twp = s_reg.twp + 6'h1;
    end
    if (tpop) begin
      s_next.trp = s_reg.trp + 6'h1;
    end
    s_next.tnum = s_reg.tnum + {6'h0, tpush} - {6'h0, tpop};
    s_next.rsp.awready = !s_next.aw_full;
    s_next.rsp.wready = !s_next.w_full;
  end

  // ==========================================
  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.cfg.ctrl <= RST_CTRL;
      s_reg.cfg.rate <= RST_RATE;
      s_reg.cfg.tmr <= RST_TMR;
      s_reg.cfg.maxpl <= RST_MAXPL;
      s_reg.rs <= S_IDLE;
      s_reg.ts <= S_IDLE;
      s_reg.txd <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign axi_rsp = s_reg.rsp;
  assign txd = s_reg.txd;
  assign cts_n = s_reg.cts_n;
  assign ptx = s_reg.ptx;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_cts_throttle: assert property (s_reg.cfg.ctrl.receive_throttle_enable && // [R7]
    rfree <= CTS_STOP_FREE |=> s_reg.cts_n) else $error("cts not raised");
  a_cts_release: assert property (s_reg.cfg.ctrl.receive_throttle_enable && // [R8]
    rfree >= CTS_GO_FREE |=> !s_reg.cts_n) else $error("cts not released");
  a_holdoff_idle: assert property (s_reg.cfg.ctrl.output_holdoff_enable && rts_n && // [R10]
    s_reg.ts == S_IDLE |=> s_reg.ts == S_IDLE) else $error("output during hold-off");
  a_frame_bits: assert property ((s_reg.ts == S_START |-> !s_reg.txd) and // [R2]
    (s_reg.ts == S_STOP |-> s_reg.txd)) else $error("bad frame level");
  a_defer_rx: assert property (radio_rx_busy && s_reg.burst == 7'h0 |=> // [R5]
    s_reg.burst == 7'h0) else $error("drained while radio busy");
  a_full_payload: assert property (s_reg.burst == 7'h0 && !radio_rx_busy && // [R17]
    maxpl != 7'h0 && s_reg.rnum >= maxpl |=> s_reg.burst == $past(maxpl))
    else $error("full payload not packetized");
  a_zero_tmo: assert property (s_reg.cfg.tmr.packetize_silence_timeout == 8'h0 && // [R15]
    s_reg.burst == 7'h0 && s_reg.rnum != 7'h0 && !radio_rx_busy && maxpl != 7'h0 |=>
    ##1 s_reg.ptx.valid)
    else $error("no immediate packetize");
  a_drop_whole: assert property (prx.start && {1'b0, tfree} < // [R6]
    ({1'b0, prx.len} + {7'h0, s_reg.cfg.ctrl.framed}) ##1 (prx.valid && !prx.start)
    |=> s_reg.tnum <= $past(s_reg.tnum)) else $error("partial packet stored");
  a_cmd_drop: assert property (ch_ev && s_reg.cfg.ctrl.cmdmode && pop == 1'b0 && // [R22]
    s_reg.rep == 2'h0 && !s_reg.hold_v |=> s_reg.rnum == $past(s_reg.rnum))
    else $error("command char forwarded");
  a_rx_store: assert property (ch_ev && !s_reg.cfg.ctrl.cmdmode && s_reg.ccnt == 2'h0 && // [R4]
    !pop && s_reg.rnum != BUF_DEPTH && s_reg.rep == 2'h0 && !s_reg.hold_v &&
    s_reg.rsh != s_reg.cfg.tmr.command_entry_character |=> s_reg.rnum == $past(s_reg.rnum) + 7'h1)
    else $error("char not stored");
  c_cmd_enter: cover property ($rose(s_reg.cfg.ctrl.cmdmode));
  c_pkt_last: cover property (s_reg.ptx.valid && s_reg.ptx.last && ptx_ready);
  c_cts_high: cover property ($rose(s_reg.cts_n));
  c_pkt_drop: cover property (prx.start ##1 s_reg.drop);
endmodule
`default_nettype wire

// ---- hsp_host_model.sv ----
// Purpose: Host UART model at the serial pins
// Assumes: 8 data bits, no parity, one stop bit
// Notes: One bit lasts BIT clocks
`default_nettype none
module hsp_host_model #(parameter int BIT = 4) (
  // Clock
  input wire logic clk,
  // Serial pins
  output var logic rxd,
  input wire logic txd,
  input wire logic cts_n,
  output var logic rts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [7:0] d;
  // ==========================================
  // Line idles high, no hold-off
  initial begin
    rxd = 1'b1;
    rts_n = 1'b0;
  end
  // Send one character once throttle is off
  task automatic send(input logic [7:0] b);
    while (cts_n !== 1'b0) @(posedge clk);
    rxd <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // Collect output characters at bit centres
  initial forever begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = txd;
    end
    repeat (BIT) @(posedge clk);
    if (txd === 1'b1) got.push_back(d);
  end
endmodule
`default_nettype wire

// ---- hsp_top_tb_top.sv ----
// Purpose: Self-checking bench of the host serial port
// Assumes: Bit time shortened to 4 clocks
// Notes: Radio side driven and collected here
`default_nettype none
module hsp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hsp_pkg::*;
  localparam int BIT = 4;
  logic clk, srst, rxd, rts_n, txd, cts_n, busy, ptx_ready, stall, st_v, st_ok, ev_v;
  logic [7:0] ev_c;
  hsp_axi_req_t req;
  hsp_axi_rsp_t rsp;
  hsp_ptx_t ptx;
  hsp_prx_t prx;
  logic [7:0] pq[$];
  logic [7:0] eq[$];
  logic [7:0] b;
  logic [31:0] rd;
  logic [1:0] rr;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  // ==========================================
  // Design and host model
  hsp_top u_dut (.clk(clk), .srst(srst), .axi_req(req), .axi_rsp(rsp), .rxd(rxd),
    .rts_n(rts_n), .txd(txd), .cts_n(cts_n), .radio_rx_busy(busy), .ptx(ptx),
    .ptx_ready(ptx_ready), .prx(prx), .tx_status_valid(st_v), .tx_status_ok(st_ok),
    .event_valid(ev_v), .event_code(ev_c));
  hsp_host_model #(.BIT(BIT)) u_host (.clk(clk), .rxd(rxd), .txd(txd), .cts_n(cts_n),
    .rts_n(rts_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Radio sink with optional stalls, and timeout
  always @(posedge clk) begin
    if (ptx.valid === 1'b1 && ptx_ready === 1'b1) pq.push_back(ptx.data);
    ptx_ready <= stall ? 1'($urandom) : 1'b1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    rr = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  // One radio packet; kept bytes go to the expected queue
  task automatic radio_pkt(input int n, input bit keep);
    @(posedge clk);
    prx.start <= 1'b1;
    prx.len <= 7'(n);
    prx.src <= 8'h5a;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      b = 8'($urandom);
      if (keep) eq.push_back(b);
      prx.start <= 1'b0;
      prx.valid <= 1'b1;
      prx.data <= b;
    end
    @(posedge clk);
    prx.valid <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    req = '0;
    prx = '0;
    srst = 1'b1;
    busy = 1'b0;
    st_v = 1'b0;
    st_ok = 1'b0;
    ev_v = 1'b0;
    ev_c = 8'h00;
    stall = 1'b0;
    ptx_ready = 1'b0;
    void'($urandom(32'h73b64c36));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    axr(OFF_RATE);
    chk(rd, RST_RATE);
    axr(OFF_TMR);
    chk(rd, RST_TMR);
    // Zero packetize timeout from here on
    axw(OFF_TMR, 32'h002b_1e00);
    axr(8'h14);
    chk(32'(rr), 32'(RESP_ERR));
    axw(OFF_RATE, 32'h4);
    axr(OFF_RATE);
    chk(rd, 32'h4);
    $display("test registers done");
    stall = 1'b1;
    for (int i = 0; i < 10; i++) begin
      b = 8'($urandom);
      eq.push_back(b);
      u_host.send(b);
    end
    for (int i = 0; i < 3000 && pq.size() < 10; i++) @(posedge clk);
    for (int i = 0; i < 10; i++) chk(32'(pq[i]), 32'(eq[i]));
    $display("test serial to radio done");
    pq.delete();
    eq.delete();
    axw(OFF_CTRL, 32'h1);
    u_host.rts_n <= 1'b1;
    radio_pkt(40, 1'b1);
    radio_pkt(40, 1'b0);
    radio_pkt(20, 1'b1);
    repeat (100) @(posedge clk);
    chk(32'(u_host.got.size()), 32'h0);
    u_host.rts_n <= 1'b0;
    for (int i = 0; i < 5000 && u_host.got.size() < 60; i++) @(posedge clk);
    repeat (200) @(posedge clk);
    chk(32'(u_host.got.size()), 32'd60);
    for (int i = 0; i < 60; i++) chk(32'(u_host.got[i]), 32'(eq[i]));
    $display("test radio to serial done");
    axw(OFF_CTRL, 32'h2);
    busy <= 1'b1;
    for (int i = 0; i < 47; i++) begin
      u_host.send(8'(i));
      repeat (4) @(posedge clk);
      if (i == 45) chk(32'(cts_n), 32'h0);
    end
    chk(32'(cts_n), 32'h1);
    chk(32'(pq.size()), 32'h0);
    busy <= 1'b0;
    for (int i = 0; i < 3000 && pq.size() < 47; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(32'(cts_n), 32'h0);
    for (int i = 0; i < 47; i++) chk(32'(pq[i]), 32'(i));
    $display("test throttle done");
    // Guard of two bit times, then three command characters
    axw(OFF_TMR, 32'h002b_0200);
    repeat (40) @(posedge clk);
    for (int i = 0; i < 3; i++) u_host.send(8'h2b);
    repeat (40) @(posedge clk);
    axr(OFF_CTRL);
    chk(rd, 32'h0000_000a);
    u_host.send(8'h55);
    repeat (20) @(posedge clk);
    chk(32'(pq.size()), 32'd47);
    $display("test command sequence done");
    // Framed: source byte, payload, status, event
    axw(OFF_CTRL, 32'h4);
    u_host.got.delete();
    eq.delete();
    eq.push_back(8'h5a);
    radio_pkt(3, 1'b1);
    st_v <= 1'b1;
    ev_v <= 1'b1;
    ev_c <= 8'hc3;
    @(posedge clk);
    st_v <= 1'b0;
    ev_v <= 1'b0;
    eq.push_back(ST_FAIL);
    eq.push_back(8'hc3);
    for (int i = 0; i < 2000 && u_host.got.size() < 6; i++) @(posedge clk);
    repeat (50) @(posedge clk);
    chk(32'(u_host.got.size()), 32'd6);
    for (int i = 0; i < 6; i++) chk(32'(u_host.got[i]), 32'(eq[i]));
    $display("test framed mode done");
    report_and_stop();
  end
endmodule
`default_nettype wire
